// ---- shared/plb_pkg.sv ----
package plb_pkg;
   // widths and depths
   localparam int DW = 8;
   localparam int BW = 16;
   localparam int AW = 5;
   localparam int QUE_DEPTH = 4;
   localparam int CFG_WORDS = 8;
   localparam int N_ROUTE = 6;

   // register offsets on the system bus
   localparam logic [AW-1:0] OFS_ACC0 = 5'h00;
   localparam logic [AW-1:0] OFS_ACC1 = 5'h01;
   localparam logic [AW-1:0] OFS_OPR0 = 5'h02;
   localparam logic [AW-1:0] OFS_OPR1 = 5'h03;
   localparam logic [AW-1:0] OFS_QUE0 = 5'h04;
   localparam logic [AW-1:0] OFS_QUE1 = 5'h05;
   localparam logic [AW-1:0] OFS_CTL = 5'h06;
   localparam logic [AW-1:0] OFS_STAT = 5'h07;
   localparam logic [AW-1:0] OFS_MODE = 5'h08;
   localparam logic [AW-1:0] OFS_ORMASK = 5'h09;
   localparam logic [AW-1:0] OFS_POLY = 5'h0A;
   localparam logic [AW-1:0] OFS_CMPMASK = 5'h0B;
   localparam logic [AW-1:0] OFS_OSEL0 = 5'h0C;
   localparam logic [AW-1:0] OFS_OSEL1 = 5'h0D;
   localparam logic [AW-1:0] OFS_STICKY = 5'h0E;
   localparam logic [AW-1:0] OFS_CFG = 5'h10;

   // reset values and fixed figures
   localparam logic [BW-1:0] MODE_RST = 16'h061C;
   localparam logic [2:0] MSB_TOP = 3'h7;
   localparam logic [7:0] ONES = 8'hFF;

   // alu operations
   typedef enum logic [2:0] {
      OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR
   } plb_op_t;

   // operand sources
   typedef enum logic [1:0] {
      SRC_ACC0, SRC_ACC1, SRC_OPR0, SRC_OPR1
   } plb_src_t;

   // shifter functions
   typedef enum logic [1:0] {
      SHF_NONE, SHF_LEFT, SHF_RIGHT, SHF_SWAP
   } plb_shf_t;

   // condition select codes for routing outputs
   typedef enum logic [3:0] {
      C_CMP0_EQ, C_CMP0_LT, C_CMP1_EQ, C_CMP1_LT, C_ZERO0, C_ZERO1,
      C_ONES0, C_ONES1, C_OVF, C_COUT, C_SOUT, C_Q0_EMPTY, C_Q0_FULL,
      C_Q1_EMPTY, C_Q1_FULL, C_CHAIN_EQ
   } plb_cond_t;

   // one dynamic configuration word
   typedef struct packed {
      logic emit;
      logic tmux;
      logic q_push;
      logic q1_ld;
      logic q0_ld;
      logic a1_we;
      logic a0_we;
      plb_shf_t shf;
      plb_src_t srcb;
      plb_src_t srca;
      plb_op_t op;
   } plb_cfg_t;

   // static mode register
   typedef struct packed {
      logic [2:0] rsv;
      logic sc_src_rt;
      logic dp_src_rt;
      logic sc_en;
      logic dp_en;
      logic cmp1_rhs_a1;
      logic cmp1_lhs_a1;
      logic chain_en;
      logic crc_en;
      logic [2:0] msb;
      logic q1_out;
      logic q0_out;
   } plb_mode_t;

   // system bus request and answer
   typedef struct packed {
      logic wr;
      logic rd;
      logic [AW-1:0] addr;
      logic [BW-1:0] wdata;
   } plb_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [BW-1:0] rdata;
   } plb_bus_rsp_t;

   // neighbour chaining
   typedef struct packed {
      logic carry;
      logic shift;
      logic cmp_eq;
   } plb_chain_t;
endpackage

// ---- src/plb_queue.sv ----
`timescale 1ns/10ps
module plb_queue #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // fill side
   input wire logic push,
   input wire logic [W-1:0] push_data,
   // drain side
   input wire logic pop,
   output logic [W-1:0] head,
   // status
   output logic empty,
   output logic full
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [PW:0] cnt;
      logic [W-1:0] q;
   } plb_queue_state_t;

   plb_queue_state_t s_r, s_nxt;
   logic do_push, do_pop;

   // refuse push when full and pop when empty
   assign do_push = push && (s_r.cnt != FULL_CNT);
   assign do_pop = pop && (s_r.cnt != '0);

   // pointers, count and show-ahead head register
   always_comb begin
      s_nxt = s_r;
      if (do_push) begin
         s_nxt.mem[s_r.wr] = push_data;
         s_nxt.wr = s_r.wr + 1'b1;
      end
      if (do_pop) begin
         s_nxt.rd = s_r.rd + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
      if (s_nxt.cnt != '0) begin
         s_nxt.q = s_nxt.mem[s_nxt.rd]; // empty keeps last word
      end
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign head = s_r.q;
   assign empty = (s_r.cnt == '0);
   assign full = (s_r.cnt == FULL_CNT);

   // checks
   chk_full_drop: assert property (@(posedge mclk) disable iff (!resetn)
      full && push && !pop |=> full && $stable(s_r.wr))
      else $error("push into full queue changed it");
   chk_empty_hold: assert property (@(posedge mclk) disable iff (!resetn)
      empty && pop && !push |=> empty && $stable(head))
      else $error("pop from empty queue changed head");
   cov_queue_full: cover property (@(posedge mclk) disable iff (!resetn)
      full && push);
endmodule

// ---- src/plb_skid.sv ----
`timescale 1ns/10ps
module plb_skid #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic v0;
      logic v1;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } plb_skid_state_t;

   plb_skid_state_t s_r, s_nxt;
   logic take, give;

   assign take = in_valid && !s_r.v1;
   assign give = s_r.v0 && out_ready;

   // two slots, oldest word always in slot zero
   always_comb begin
      s_nxt = s_r;
      if (give) begin
         s_nxt.v0 = s_r.v1;
         s_nxt.d0 = s_r.d1;
         s_nxt.v1 = 1'b0;
      end
      if (take) begin
         if (!s_nxt.v0) begin
            s_nxt.v0 = 1'b1;
            s_nxt.d0 = in_data;
         end else begin
            s_nxt.v1 = 1'b1;
            s_nxt.d1 = in_data;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready = !s_r.v1;
   assign out_valid = s_r.v0;
   assign out_data = s_r.d0;

   // checks
   chk_hold_out: assert property (@(posedge mclk) disable iff (!resetn)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("stalled stream word changed or dropped");
   cov_skid_full: cover property (@(posedge mclk) disable iff (!resetn)
      s_r.v1 && in_valid);
endmodule

// ---- src/plb_datapath.sv ----
`timescale 1ns/10ps
module plb_datapath #(
   parameter int QDEPTH = plb_pkg::QUE_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // system bus
   input wire plb_pkg::plb_bus_req_t bus_req,
   output plb_pkg::plb_bus_rsp_t bus_rsp,
   // routing matrix
   input wire logic [5:0] rt_in,
   output logic [5:0] rt_out,
   // neighbour chaining
   input wire plb_pkg::plb_chain_t chain_in,
   output plb_pkg::plb_chain_t chain_out,
   // status and control
   output logic [7:0] ctl_out,
   input wire logic [7:0] st_in,
   // result stream
   output logic res_valid,
   output logic [7:0] res_data,
   input wire logic res_ready
);
   typedef struct packed {
      logic [7:0] acc0;
      logic [7:0] acc1;
      logic [7:0] opr0;
      logic [7:0] opr1;
      logic carry;
      logic sout;
      logic [7:0] ctl;
      logic [7:0] sticky;
      logic [7:0] latch;
      plb_pkg::plb_mode_t mode;
      logic [7:0] ormask;
      logic [7:0] poly;
      logic [15:0] cmpmask;
      logic [15:0] osel0;
      logic [7:0] osel1;
      logic [plb_pkg::CFG_WORDS-1:0][15:0] cfg;
      logic rvalid;
      logic [15:0] rdata;
      logic [5:0] route;
   } plb_dp_state_t;

   localparam plb_dp_state_t ST_RST = '{mode: plb_pkg::MODE_RST,
                                       default: '0};

   plb_dp_state_t s_r, s_nxt;
   plb_pkg::plb_cfg_t cfg;
   logic [3:0][7:0] regs;
   logic [5:0][3:0] sels;
   logic [7:0] src_a, src_b, wmask, am, bm, bx, alu, crc, shf, res;
   logic [7:0] l1, r1;
   logic [8:0] sum;
   logic [3:0] cpos;
   logic [15:0] cond;
   logic ci, sin, cout, sout, fb, ovf, eq0_raw, eq0, lt0, eq1, lt1;
   logic dp_clk, dp_go, sc_go, sk_ready;
   logic wr_acc0, stat_rd, wr_cfg;
   logic q0_push, q0_pop, q0_empty, q0_full;
   logic q1_push, q1_pop, q1_empty, q1_full;
   logic [7:0] q0_head, q1_head, q0_in, q1_in;

   // active configuration word from the routed address
   assign cfg = s_r.cfg[rt_in[2:0]];

   // clock select and enable per subcomponent, stall on stream back-pressure
   assign dp_clk = s_r.mode.dp_src_rt ? rt_in[5] : s_r.mode.dp_en;
   assign sc_go = s_r.mode.sc_src_rt ? rt_in[4] : s_r.mode.sc_en;
   assign dp_go = dp_clk && !(cfg.emit && !sk_ready);

   // bus decode helpers
   assign wr_acc0 = bus_req.wr && (bus_req.addr == plb_pkg::OFS_ACC0);
   assign stat_rd = bus_req.rd && (bus_req.addr == plb_pkg::OFS_STAT);
   assign wr_cfg = bus_req.wr && (bus_req.addr[4:3] == plb_pkg::OFS_CFG[4:3]);

   // operand selection among the four working registers
   assign regs = {s_r.opr1, s_r.opr0, s_r.acc1, s_r.acc0};
   assign src_a = regs[cfg.srca];
   assign src_b = regs[cfg.srcb];

   // carry and shift-in: registered or chained, else carry set by the operation and shift-in routed
   always_comb begin
      if (cfg.tmux) begin
         ci = s_r.carry;
         sin = s_r.sout;
      end else if (s_r.mode.chain_en) begin
         ci = chain_in.carry;
         sin = chain_in.shift;
      end else begin
         ci = (cfg.op == plb_pkg::OP_SUB);
         sin = rt_in[3];
      end
   end

   // alu, crc step, shifter and mask with a variable msb
   always_comb begin
      wmask = plb_pkg::ONES >> (plb_pkg::MSB_TOP - s_r.mode.msb);
      am = src_a & wmask;
      bm = src_b & wmask;
      bx = (cfg.op == plb_pkg::OP_SUB) ? (~bm & wmask) : bm;
      case (cfg.op)
         plb_pkg::OP_INC: sum = {1'b0, am} + 9'h001;
         plb_pkg::OP_DEC: sum = {1'b0, am} + {1'b0, wmask};
         plb_pkg::OP_ADD: sum = {1'b0, am} + {1'b0, bx} + {8'h00, ci};
         plb_pkg::OP_SUB: sum = {1'b0, am} + {1'b0, bx} + {8'h00, ci};
         plb_pkg::OP_AND: sum = {1'b0, am & bm};
         plb_pkg::OP_OR: sum = {1'b0, am | bm};
         plb_pkg::OP_XOR: sum = {1'b0, am ^ bm};
         default: sum = {1'b0, am};
      endcase
      cpos = {1'b0, s_r.mode.msb} + 4'h1;
      cout = sum[cpos];
      ovf = (am[s_r.mode.msb] == bx[s_r.mode.msb]) &&
            (sum[s_r.mode.msb] != am[s_r.mode.msb]);
      fb = am[s_r.mode.msb] ^ sin;
      crc = ((am << 1) & wmask) ^ (fb ? (s_r.poly & wmask) : 8'h00);
      alu = s_r.mode.crc_en ? crc : (sum[7:0] & wmask);
      case (cfg.shf)
         plb_pkg::SHF_LEFT: begin
            shf = ((alu << 1) | {7'h00, sin}) & wmask;
            sout = alu[s_r.mode.msb];
         end
         plb_pkg::SHF_RIGHT: begin
            shf = (alu >> 1) | ({7'h00, sin} << s_r.mode.msb);
            sout = alu[0];
         end
         plb_pkg::SHF_SWAP: begin
            shf = {alu[3:0], alu[7:4]};
            sout = 1'b0;
         end
         default: begin
            shf = alu;
            sout = s_r.mode.crc_en && am[s_r.mode.msb];
         end
      endcase
      res = shf | s_r.ormask;
   end

   // masked comparators
   assign l1 = s_r.mode.cmp1_lhs_a1 ? s_r.acc1 : s_r.acc0;
   assign r1 = s_r.mode.cmp1_rhs_a1 ? s_r.acc1 : s_r.opr1;
   assign eq0_raw = ((s_r.acc0 ^ s_r.opr0) & s_r.cmpmask[7:0]) == 8'h00;
   assign eq0 = eq0_raw && (!s_r.mode.chain_en || chain_in.cmp_eq);
   assign lt0 = (s_r.acc0 & s_r.cmpmask[7:0]) < (s_r.opr0 & s_r.cmpmask[7:0]);
   assign eq1 = ((l1 ^ r1) & s_r.cmpmask[15:8]) == 8'h00;
   assign lt1 = (l1 & s_r.cmpmask[15:8]) < (r1 & s_r.cmpmask[15:8]);

   // condition vector in select-code order
   assign cond = {chain_in.cmp_eq, q1_full, q1_empty, q0_full, q0_empty,
                  sout, cout, ovf,
                  s_r.acc1 == plb_pkg::ONES, s_r.acc0 == plb_pkg::ONES,
                  s_r.acc1 == 8'h00, s_r.acc0 == 8'h00,
                  lt1, eq1, lt0, eq0};
   assign sels = {s_r.osel1, s_r.osel0};

   // queue direction steering
   always_comb begin
      if (s_r.mode.q0_out) begin
         q0_push = dp_go && cfg.q_push;
         q0_pop = bus_req.rd && (bus_req.addr == plb_pkg::OFS_QUE0);
         q0_in = res;
      end else begin
         q0_push = bus_req.wr && (bus_req.addr == plb_pkg::OFS_QUE0);
         q0_pop = dp_go && cfg.q0_ld;
         q0_in = bus_req.wdata[7:0];
      end
      if (s_r.mode.q1_out) begin
         q1_push = dp_go && cfg.q_push;
         q1_pop = bus_req.rd && (bus_req.addr == plb_pkg::OFS_QUE1);
         q1_in = s_r.acc1;
      end else begin
         q1_push = bus_req.wr && (bus_req.addr == plb_pkg::OFS_QUE1);
         q1_pop = dp_go && cfg.q1_ld;
         q1_in = bus_req.wdata[7:0];
      end
   end

   // next state: datapath, status, routing, then bus access
   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = bus_req.rd;
      if (dp_go) begin
         if (cfg.a0_we) s_nxt.acc0 = res;
         if (cfg.q0_ld) s_nxt.acc0 = q0_head;
         if (cfg.a1_we) s_nxt.acc1 = res;
         if (cfg.q1_ld) s_nxt.opr1 = q1_head;
         s_nxt.carry = cout;
         s_nxt.sout = sout;
      end
      if (stat_rd) s_nxt.latch = 8'h00;
      if (sc_go) s_nxt.latch = s_nxt.latch | (st_in & s_r.sticky);
      for (int i = 0; i < plb_pkg::N_ROUTE; i++) begin
         s_nxt.route[i] = cond[sels[i]];
      end
      if (bus_req.wr) begin
         case (bus_req.addr)
            plb_pkg::OFS_ACC0: s_nxt.acc0 = bus_req.wdata[7:0];
            plb_pkg::OFS_ACC1: s_nxt.acc1 = bus_req.wdata[7:0];
            plb_pkg::OFS_OPR0: s_nxt.opr0 = bus_req.wdata[7:0];
            plb_pkg::OFS_OPR1: s_nxt.opr1 = bus_req.wdata[7:0];
            plb_pkg::OFS_CTL: s_nxt.ctl = bus_req.wdata[7:0];
            plb_pkg::OFS_MODE: s_nxt.mode = bus_req.wdata;
            plb_pkg::OFS_ORMASK: s_nxt.ormask = bus_req.wdata[7:0];
            plb_pkg::OFS_POLY: s_nxt.poly = bus_req.wdata[7:0];
            plb_pkg::OFS_CMPMASK: s_nxt.cmpmask = bus_req.wdata;
            plb_pkg::OFS_OSEL0: s_nxt.osel0 = bus_req.wdata;
            plb_pkg::OFS_OSEL1: s_nxt.osel1 = bus_req.wdata[7:0];
            plb_pkg::OFS_STICKY: s_nxt.sticky = bus_req.wdata[7:0];
            default: begin
               if (wr_cfg) s_nxt.cfg[bus_req.addr[2:0]] = bus_req.wdata;
            end
         endcase
      end
      if (bus_req.rd) begin
         s_nxt.rdata = 16'h0000;
         case (bus_req.addr)
            plb_pkg::OFS_ACC0: s_nxt.rdata[7:0] = s_r.acc0;
            plb_pkg::OFS_ACC1: s_nxt.rdata[7:0] = s_r.acc1;
            plb_pkg::OFS_OPR0: s_nxt.rdata[7:0] = s_r.opr0;
            plb_pkg::OFS_OPR1: s_nxt.rdata[7:0] = s_r.opr1;
            plb_pkg::OFS_QUE0: s_nxt.rdata[7:0] = q0_head;
            plb_pkg::OFS_QUE1: s_nxt.rdata[7:0] = q1_head;
            plb_pkg::OFS_CTL: s_nxt.rdata[7:0] = s_r.ctl;
            plb_pkg::OFS_STAT: begin
               s_nxt.rdata[7:0] = (s_r.latch & s_r.sticky) |
                                  (st_in & ~s_r.sticky);
            end
            plb_pkg::OFS_MODE: s_nxt.rdata = s_r.mode;
            plb_pkg::OFS_ORMASK: s_nxt.rdata[7:0] = s_r.ormask;
            plb_pkg::OFS_POLY: s_nxt.rdata[7:0] = s_r.poly;
            plb_pkg::OFS_CMPMASK: s_nxt.rdata = s_r.cmpmask;
            plb_pkg::OFS_OSEL0: s_nxt.rdata = s_r.osel0;
            plb_pkg::OFS_OSEL1: s_nxt.rdata[7:0] = s_r.osel1;
            plb_pkg::OFS_STICKY: s_nxt.rdata[7:0] = s_r.sticky;
            default: begin
               if (bus_req.addr[4:3] == plb_pkg::OFS_CFG[4:3]) begin
                  s_nxt.rdata = s_r.cfg[bus_req.addr[2:0]];
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // byte queues
   plb_queue #(.W(plb_pkg::DW), .DEPTH(QDEPTH)) u_que0 (
      .mclk(mclk),
      .resetn(resetn),
      .push(q0_push),
      .push_data(q0_in),
      .pop(q0_pop),
      .head(q0_head),
      .empty(q0_empty),
      .full(q0_full)
   );

   plb_queue #(.W(plb_pkg::DW), .DEPTH(QDEPTH)) u_que1 (
      .mclk(mclk),
      .resetn(resetn),
      .push(q1_push),
      .push_data(q1_in),
      .pop(q1_pop),
      .head(q1_head),
      .empty(q1_empty),
      .full(q1_full)
   );

   // result stream buffer
   plb_skid #(.W(plb_pkg::DW)) u_skid (
      .mclk(mclk),
      .resetn(resetn),
      .in_valid(dp_clk && cfg.emit),
      .in_ready(sk_ready),
      .in_data(res),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );

   // outputs
   assign bus_rsp = '{valid: s_r.rvalid, rdata: s_r.rdata};
   assign rt_out = s_r.route;
   assign ctl_out = s_r.ctl;
   assign chain_out = '{carry: cout, shift: sout, cmp_eq: eq0_raw};

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   chk_read_answer: assert property (bus_req.rd |=> bus_rsp.valid)
      else $error("bus read not answered next cycle");
   chk_acc_result: assert property (dp_go && cfg.a0_we && !cfg.q0_ld &&
      !wr_acc0 |=> s_r.acc0 == $past(res))
      else $error("accumulator missed alu result");
   chk_opr_hold: assert property (!(bus_req.wr &&
      bus_req.addr == plb_pkg::OFS_OPR0) |=> $stable(s_r.opr0))
      else $error("operand register changed without bus write");
   chk_queue_load: assert property (dp_go && cfg.q0_ld &&
      !wr_acc0 |=> s_r.acc0 == $past(q0_head))
      else $error("accumulator missed queue word");
   chk_cfg_store: assert property (wr_cfg |=>
      s_r.cfg[$past(bus_req.addr[2:0])] == $past(bus_req.wdata))
      else $error("configuration word not stored");
   chk_carry_reg: assert property (dp_go |=>
      s_r.carry == $past(cout) && s_r.sout == $past(sout))
      else $error("carry or shift out not registered");
   chk_route_sel: assert property (1'b1 |=>
      rt_out[0] == $past(cond[s_r.osel0[3:0]]))
      else $error("routing output shows wrong condition");
   chk_ctl_drive: assert property (bus_req.wr &&
      bus_req.addr == plb_pkg::OFS_CTL |=>
      ctl_out == $past(bus_req.wdata[7:0]))
      else $error("control bits not driven from bus write");
   chk_sticky_clear: assert property (stat_rd &&
      !(sc_go && |(st_in & s_r.sticky)) |=> s_r.latch == 8'h00)
      else $error("status read did not clear sticky bits");
   chk_sticky_hold: assert property (!stat_rd |=>
      (s_r.latch & $past(s_r.latch)) == $past(s_r.latch))
      else $error("sticky bit lost without read");

   cov_add_step: cover property (dp_go && cfg.op == plb_pkg::OP_ADD &&
      cfg.a0_we);
   cov_stream_stall: cover property (dp_clk && cfg.emit && !sk_ready);
   cov_sticky_read: cover property (stat_rd && s_r.latch != 8'h00);
endmodule

// ---- tb/plb_host.sv ----
`timescale 1ns/10ps
module plb_host (
   // clock
   input wire logic mclk,
   // system bus
   output plb_pkg::plb_bus_req_t bus_req,
   input wire plb_pkg::plb_bus_rsp_t bus_rsp
);
   // idle bus at time zero
   initial bus_req = '0;
   // one access: strobe for one edge, answer taken at the following edge
   task automatic acc(input logic w, input logic [4:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic v);
      @(posedge mclk);
      bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
      @(posedge mclk);
      q = bus_rsp.rdata;
      v = bus_rsp.valid;
   endtask
endmodule

// ---- tb/plb_datapath_bench.sv ----
`timescale 1ns/10ps
module plb_datapath_bench;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic res_ready = 1'b0;
   logic [5:0] rt_in = '0;
   logic [7:0] st_in = '0;
   logic [15:0] q;
   logic v;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   plb_pkg::plb_bus_req_t bus_req;
   plb_pkg::plb_bus_rsp_t bus_rsp;
   plb_pkg::plb_chain_t chain_out;
   logic [5:0] rt_out;
   logic [7:0] ctl_out;
   logic [7:0] res_data;
   logic res_valid;
   // clock and cycle ceiling
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   plb_datapath DUT (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .rt_in(rt_in), .rt_out(rt_out), .chain_in('0),
      .chain_out(chain_out), .ctl_out(ctl_out), .st_in(st_in),
      .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
   plb_host HOST (.mclk(mclk), .bus_req(bus_req), .bus_rsp(bus_rsp));
   // shared compare and bus helpers
   task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [15:0] d);
      HOST.acc(1'b1, a, d, q, v);
      cmp("wr valid", 16'h0000, {15'h0000, v});
   endtask
   task automatic rd(logic [4:0] a);
      HOST.acc(1'b0, a, 16'h0000, q, v);
      cmp("rd valid", 16'h0001, {15'h0000, v});
   endtask
   // reset value, read-back, unmapped index
   task automatic t_regs();
      rd(plb_pkg::OFS_MODE);
      cmp("mode", plb_pkg::MODE_RST, q);
      for (int i = 0; i < 4; i++) begin
         wr(5'(i), 16'hFF5A + 16'(i));
         rd(5'(i));
         cmp("work reg", 16'(8'h5A + 8'(i)), q);
      end
      rd(5'h1F);
      cmp("unmapped", 16'h0000, q);
   endtask
   // every alu operation on acc0 and opr0, result streamed too
   task automatic t_alu();
      logic [7:0] want [8] = '{8'h35, 8'h36, 8'h34, 8'h44, 8'h26, 8'h05,
         8'h3F, 8'h3A};
      wr(plb_pkg::OFS_OPR0, 16'h000F);
      for (int op = 0; op < 8; op++) begin
         wr(plb_pkg::OFS_CFG + 5'h01, 16'h8240 | 16'(op));
         wr(plb_pkg::OFS_ACC0, 16'h0035);
         @(posedge mclk) rt_in <= 6'h01;
         @(posedge mclk) rt_in <= 6'h00;
         rd(plb_pkg::OFS_ACC0);
         cmp("alu", {8'h00, want[op]}, q);
         cmp("stream", {7'h00, 1'b1, want[op]}, {7'h00, res_valid, res_data});
         @(posedge mclk) res_ready <= 1'b1;
         @(posedge mclk) res_ready <= 1'b0;
      end
   endtask
   // fill queue0 past full, drain it into acc0
   task automatic t_queue();
      wr(plb_pkg::OFS_OSEL0, 16'h00BC);
      wr(plb_pkg::OFS_CFG + 5'h02, 16'h0800);
      for (int i = 0; i < 5; i++) wr(plb_pkg::OFS_QUE0, 16'(8'h10 + i));
      cmp("full", 16'h0001, {14'h0000, rt_out[1:0]});
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) rt_in <= 6'h02;
         @(posedge mclk) rt_in <= 6'h00;
         rd(plb_pkg::OFS_ACC0);
         cmp("queue", 16'(8'h10 + i), q);
      end
      cmp("empty", 16'h0002, {14'h0000, rt_out[1:0]});
   endtask
   // control drive-out, live and sticky status
   task automatic t_stat();
      wr(plb_pkg::OFS_CTL, 16'h00A5);
      cmp("ctl", 16'h00A5, {8'h00, ctl_out});
      wr(plb_pkg::OFS_STICKY, 16'h0001);
      @(posedge mclk) st_in <= 8'h3D;
      @(posedge mclk) st_in <= 8'h3C;
      rd(plb_pkg::OFS_STAT);
      cmp("status", 16'h003D, q);
      rd(plb_pkg::OFS_STAT);
      cmp("cleared", 16'h003C, q);
   endtask
   // compare chain-out, then shift left with serial in and or-mask
   task automatic t_misc();
      wr(plb_pkg::OFS_CMPMASK, 16'hFFFF);
      wr(plb_pkg::OFS_ACC0, 16'h0035);
      wr(plb_pkg::OFS_OPR0, 16'h0035);
      cmp("chain", 16'h0001, {13'h0000, chain_out});
      wr(plb_pkg::OFS_CFG + 5'h03, 16'h0280);
      wr(plb_pkg::OFS_ORMASK, 16'h0080);
      @(posedge mclk) rt_in <= 6'h0B;
      @(posedge mclk) rt_in <= 6'h00;
      rd(plb_pkg::OFS_ACC0);
      cmp("shift", 16'h00EB, q);
   endtask
   // verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      t_regs();
      t_alu();
      t_queue();
      t_stat();
      t_misc();
      results();
   end
endmodule
